// ==== rtl/pml_pkg.sv ====
// package: constants and types for the power meter limit status readout
package pml_pkg;
    localparam int PML_TEL_BYTES    = 16;
    localparam int PML_HDR_BYTES    = 4;
    localparam int PML_DATA_BYTES   = 12;
    localparam logic [7:0] PML_ID_MIN    = 8'h01;
    localparam logic [7:0] PML_ID_MAX    = 8'h29;
    localparam logic [7:0] PML_ID_ENERGY_LAST = 8'h08;
    localparam logic [7:0] PML_ID_PTOT_FIRST  = 8'h09;
    localparam logic [7:0] PML_ID_PTOT_LAST   = 8'h0B;
    localparam logic [7:0] PML_ID_OVF_CONS    = 8'h27;
    localparam logic [7:0] PML_ID_OVF_PROD    = 8'h28;
    localparam logic [7:0] PML_ID_STATUS      = 8'h29;
    localparam logic [3:0] PML_SET_MIN   = 4'h1;
    localparam logic [3:0] PML_SET_MAX   = 4'hF;
    localparam logic [2:0] PML_TT_READ   = 3'h1;
    localparam logic [2:0] PML_TT_SETFR  = 3'h2;
    localparam logic [2:0] PML_TT_READFR = 3'h3;
    localparam logic [2:0] PML_TT_CMD    = 3'h4;
    localparam logic [7:0] PML_CMD_ACK   = 8'h04;
    localparam logic [3:0] PML_ST_OK     = 4'h0;
    localparam logic [3:0] PML_ST_DSID   = 4'h2;
    localparam logic [3:0] PML_ST_FRBIG  = 4'h4;
    localparam logic [3:0] PML_ST_NOFR   = 4'h5;
    localparam logic [3:0] PML_ST_NOID   = 4'h6;
    localparam logic [3:0] PML_ST_CMD    = 4'h7;
    localparam logic [3:0] PML_ST_TYPE   = 4'h9;
    localparam logic [3:0] PML_LEN_VALUE = 4'h4;
    localparam int PML_FRAME_MAX    = 3;
    // float limits: 5.497558e8, 3.75e6, -3.75e6
    localparam logic [31:0] PML_F_ENERGY_MAX = 32'h4E031270;
    localparam logic [31:0] PML_F_PTOT_MAX   = 32'h4A64E1C0;
    localparam logic [31:0] PML_F_PTOT_MIN   = 32'hCA64E1C0;
    localparam logic [31:0] PML_F_ZERO       = 32'h00000000;
    localparam logic [31:0] PML_F_ONE_WH     = 32'h3F800000;
    // status word bit positions
    localparam int PML_B_UV2 = 0;
    localparam int PML_B_UV3 = 1;
    localparam int PML_B_OV1 = 2;
    localparam int PML_B_OT  = 5;
    localparam int PML_B_UF  = 6;
    localparam int PML_B_OF  = 7;
    localparam int PML_B_RST = 8;
    localparam int PML_B_OC1 = 9;
    localparam int PML_B_PF1 = 12;
    localparam int PML_B_UV1 = 15;
    localparam logic [31:0] PML_STATUS_USED = 32'h0000FFFF;
    localparam logic [31:0] PML_STATUS_RESET = 32'h00000100;
    typedef logic [7:0] pml_tel_t [PML_TEL_BYTES];
endpackage

// ==== rtl/pml_link_if.sv ====
// interface: 16-byte request and response telegram link
`timescale 1ns/1ps
interface pml_link_if;
    logic       reqValid;
    logic [7:0] reqByte [16];
    logic       rspValid;
    logic [7:0] rspByte [16];
    modport meter (input reqValid, input reqByte, output rspValid, output rspByte);
    modport head  (output reqValid, output reqByte, input rspValid, input rspByte);
endinterface

// ==== rtl/pml_meter.sv ====
// meter end: measurand map, limit status word and telegram responder
`timescale 1ns/1ps
module pml_meter
    import pml_pkg::*;
#(
    parameter int NUM_IDS = 41
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    pml_link_if.meter        link,
    input  wire logic        measValid,
    input  wire logic [31:0] measValue [NUM_IDS],
    input  wire logic [31:0] currentTransformerFactor,
    input  wire logic [15:0] limitRaw,
    output logic             limitLed,
    output logic [3:0]       measurementSetIndex,
    output logic [31:0]      limitViolationStatus
);
    typedef struct packed {
        logic [31:0]             status;
        logic [3:0]              setIdx;
        logic                    led;
        logic                    rspValid;
        logic [PML_TEL_BYTES*8-1:0] rsp;
        logic [PML_FRAME_MAX*8-1:0] frame;
        logic [1:0]              frameLen;
        logic [NUM_IDS*32-1:0]   snap;
        logic [31:0]             resolution;
    } pml_meter_state_t;

    pml_meter_state_t st;
    pml_meter_state_t next_st;

    function automatic logic [31:0] pml_value(input logic [7:0] id, input logic [NUM_IDS*32-1:0] snap,
                                              input logic [31:0] status);
        logic [31:0] v;
        v = snap[32*(int'(id) - 1) +: 32];
        if (id == PML_ID_STATUS) begin
            v = status & PML_STATUS_USED;
        end else if (id == PML_ID_OVF_CONS || id == PML_ID_OVF_PROD) begin
            v = PML_F_ZERO;
        end else if (id >= PML_ID_PTOT_FIRST && id <= PML_ID_PTOT_LAST) begin
            if (!v[31] && v > PML_F_PTOT_MAX) v = PML_F_PTOT_MAX;
            if (v[31] && v > PML_F_PTOT_MIN) v = PML_F_PTOT_MIN;
        end else if (id <= PML_ID_ENERGY_LAST) begin
            if (v[31]) v = PML_F_ZERO;
            else if (v > PML_F_ENERGY_MAX) v = PML_F_ENERGY_MAX;
        end
        return v;
    endfunction

    function automatic logic id_ok(input logic [7:0] id);
        return id >= PML_ID_MIN && id <= PML_ID_MAX && int'(id) <= NUM_IDS;
    endfunction

    always_comb begin
        logic [2:0]  ttype;
        logic [7:0]  id;
        logic [3:0]  ulen;
        logic [31:0] v;
        logic [3:0]  code;
        next_st = st;
        ttype = link.reqByte[0][6:4];
        id = link.reqByte[1];
        ulen = link.reqByte[2][7:4];
        v = '0;
        code = PML_ST_OK;
        next_st.rspValid = 1'b0;
        next_st.resolution = currentTransformerFactor;
        if (measValid) begin
            for (int i = 0; i < NUM_IDS; i++) begin
                next_st.snap[32*i +: 32] = measValue[i];
            end
            next_st.setIdx = (st.setIdx == PML_SET_MAX) ? PML_SET_MIN : st.setIdx + 4'h1;
            next_st.status[15:0] = st.status[15:0] | {limitRaw[15:9], 1'b0, limitRaw[7:0]};
            if (|limitRaw[15:9] || |limitRaw[7:0]) next_st.led = 1'b1;
        end
        if (link.reqValid) begin
            next_st.rspValid = 1'b1;
            next_st.rsp = '0;
            unique case (ttype)
                PML_TT_READ: begin
                    if (!id_ok(id)) code = PML_ST_NOID;
                    else v = pml_value(id, st.snap, st.status);
                end
                PML_TT_SETFR: begin
                    if (ulen > 4'(PML_FRAME_MAX)) code = PML_ST_FRBIG;
                    else begin
                        next_st.frameLen = ulen[1:0];
                        for (int i = 0; i < PML_FRAME_MAX; i++) begin
                            next_st.frame[8*i +: 8] = link.reqByte[PML_HDR_BYTES + i];
                        end
                    end
                end
                PML_TT_READFR: begin
                    if (st.frameLen == 2'd0) code = PML_ST_NOFR;
                end
                PML_TT_CMD: begin
                    if (link.reqByte[PML_HDR_BYTES] == PML_CMD_ACK) begin
                        next_st.status = '0;
                        next_st.led = 1'b0;
                        // a measurement landing with the acknowledge keeps its new flags
                        if (measValid) begin
                            next_st.status[15:0] = {limitRaw[15:9], 1'b0, limitRaw[7:0]};
                            if (|limitRaw[15:9] || |limitRaw[7:0]) next_st.led = 1'b1;
                        end
                    end else code = PML_ST_CMD;
                end
                default: code = PML_ST_TYPE;
            endcase
            next_st.rsp[8*(PML_TEL_BYTES-1) +: 8] = {1'b0, ttype, code};
            next_st.rsp[8*(PML_TEL_BYTES-2) +: 8] = id;
            next_st.rsp[8*(PML_TEL_BYTES-3) +: 8] = {(code == PML_ST_OK && ttype == PML_TT_READ) ? PML_LEN_VALUE : 4'h0,
                                                     st.setIdx};
            if (ttype == PML_TT_READFR && code == PML_ST_OK) begin
                for (int i = 0; i < PML_FRAME_MAX; i++) begin
                    if (i < int'(st.frameLen) && id_ok(st.frame[8*i +: 8]))
                        next_st.rsp[8*(PML_DATA_BYTES-4*i-4) +: 32] = pml_value(st.frame[8*i +: 8], st.snap, st.status);
                end
                next_st.rsp[8*(PML_TEL_BYTES-3)+4 +: 4] = {st.frameLen, 2'b00};
            end else begin
                next_st.rsp[8*(PML_DATA_BYTES-4) +: 32] = v;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st <= '0;
            st.status <= PML_STATUS_RESET;
            st.setIdx <= PML_SET_MIN;
            st.resolution <= PML_F_ONE_WH;
        end else begin
            st <= next_st;
        end
    end

    assign link.rspValid = st.rspValid;
    generate
        for (genvar b = 0; b < PML_TEL_BYTES; b++) begin : g_rsp
            assign link.rspByte[b] = st.rsp[8*(PML_TEL_BYTES-1-b) +: 8];
        end
    endgenerate
    assign limitLed = st.led;
    assign measurementSetIndex = st.setIdx;
    assign limitViolationStatus = st.status;
endmodule

// ==== rtl/pml_head.sv ====
// head end: issues request telegrams and captures responses
`timescale 1ns/1ps
module pml_head
    import pml_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    pml_link_if.head         link,
    input  wire logic        cmdValid,
    input  wire logic [2:0]  cmdType,
    input  wire logic [7:0]  cmdId,
    input  wire logic [3:0]  cmdLen,
    input  wire logic [7:0]  cmdData [PML_DATA_BYTES],
    output logic             cmdBusy,
    output logic             rspDone,
    output logic [3:0]       rspStatus,
    output logic [3:0]       rspSetIndex,
    output logic [31:0]      rspWord
);
    typedef enum logic [0:0] {PML_IDLE, PML_WAIT} pml_head_fsm_t;
    typedef struct packed {
        pml_head_fsm_t              fsm;
        logic                       reqValid;
        logic [PML_TEL_BYTES*8-1:0] req;
        logic                       done;
        logic [3:0]                 status;
        logic [3:0]                 setIdx;
        logic [31:0]                word;
    } pml_head_state_t;

    pml_head_state_t st;
    pml_head_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.reqValid = 1'b0;
        next_st.done = 1'b0;
        unique case (st.fsm)
            PML_IDLE: begin
                if (cmdValid) begin
                    next_st.reqValid = 1'b1;
                    next_st.req = '0;
                    next_st.req[8*(PML_TEL_BYTES-1) +: 8] = {1'b0, cmdType, 4'h0};
                    next_st.req[8*(PML_TEL_BYTES-2) +: 8] = cmdId;
                    next_st.req[8*(PML_TEL_BYTES-3) +: 8] = {cmdLen, 4'h0};
                    for (int i = 0; i < PML_DATA_BYTES; i++) begin
                        next_st.req[8*(PML_DATA_BYTES-1-i) +: 8] = cmdData[i];
                    end
                    next_st.fsm = PML_WAIT;
                end
            end
            PML_WAIT: begin
                if (link.rspValid) begin
                    next_st.done = 1'b1;
                    next_st.status = link.rspByte[0][3:0];
                    next_st.setIdx = link.rspByte[2][3:0];
                    next_st.word = {link.rspByte[4], link.rspByte[5], link.rspByte[6], link.rspByte[7]};
                    next_st.fsm = PML_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st <= '0;
            st.fsm <= PML_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign link.reqValid = st.reqValid;
    generate
        for (genvar b = 0; b < PML_TEL_BYTES; b++) begin : g_req
            assign link.reqByte[b] = st.req[8*(PML_TEL_BYTES-1-b) +: 8];
        end
    endgenerate
    assign cmdBusy = (st.fsm == PML_WAIT);
    assign rspDone = st.done;
    assign rspStatus = st.status;
    assign rspSetIndex = st.setIdx;
    assign rspWord = st.word;
endmodule

// ==== test/pml_link_monitor.sv ====
// checker: telegram link timing, header fields and value bounds
`timescale 1ns/1ps
module pml_link_monitor
    import pml_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       reqValid,
    input wire logic [7:0] reqByte [16],
    input wire logic       rspValid,
    input wire logic [7:0] rspByte [16]
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic [7:0]  id;
    logic [31:0] w;
    logic        rd;
    assign id = rspByte[1];
    assign w  = {rspByte[4], rspByte[5], rspByte[6], rspByte[7]};
    assign rd = rspValid && rspByte[0] == {1'h0, PML_TT_READ, PML_ST_OK};
    rsp_timing_a: assert property (reqValid |=> rspValid)
        else $error("no response after request");
    rsp_cause_a: assert property (rspValid |-> $past(reqValid))
        else $error("response without request");
    hdr_fixed_a: assert property (rspValid |-> !rspByte[0][7] && rspByte[3] == 8'h00)
        else $error("reserved header bits set");
    set_index_a: assert property (rspValid |-> rspByte[2][3:0] != 4'h0)
        else $error("set index zero");
    err_nodata_a: assert property (rspValid && rspByte[0][3:0] != 4'h0 |-> rspByte[2][7:4] == 4'h0)
        else $error("error response carries data");
    bad_id_a: assert property (reqValid && !(reqByte[1] inside {[PML_ID_MIN:PML_ID_MAX]})
        && reqByte[0][6:4] == PML_TT_READ |=> rspByte[0][3:0] == PML_ST_NOID) else $error("bad id accepted");
    id_echo_a: assert property (rd |-> id == reqByte[1])
        else $error("wrong id answered");
    energy_bound_a: assert property (rd && id inside {[PML_ID_MIN:PML_ID_ENERGY_LAST]}
        |-> !w[31] && w <= PML_F_ENERGY_MAX) else $error("energy out of range");
    ptot_bound_a: assert property (rd && id inside {[PML_ID_PTOT_FIRST:PML_ID_PTOT_LAST]}
        |-> w[30:0] <= PML_F_PTOT_MAX[30:0]) else $error("total power out of range");
    ovf_zero_a: assert property (rd && (id == PML_ID_OVF_CONS || id == PML_ID_OVF_PROD) |-> w == PML_F_ZERO)
        else $error("overflow count not zero");
    status_rsv_a: assert property (rd && id == PML_ID_STATUS
        |-> rspByte[4] == 8'h00 && rspByte[5] == 8'h00 && rspByte[2][7:4] == PML_LEN_VALUE) else $error("reserved set");
    cover property (rd && id == PML_ID_STATUS);
    cover property (rspValid && rspByte[0][3:0] != 4'h0);
    cover property (rspValid && rspByte[0][6:4] == PML_TT_CMD);
endmodule

// ==== test/tb.sv ====
// testbench: head and meter ends joined over the telegram link
`timescale 1ns/1ps
module tb
    import pml_pkg::*;
;
    logic        clk_sys = 1'h0, resetn = 1'h0, measValid = 1'h0, cmdValid = 1'h0;
    logic [31:0] measValue [41];
    logic [31:0] ctFactor = PML_F_ONE_WH, seed = 32'hA09E00DD, expStat = PML_STATUS_RESET, rv;
    logic [15:0] limitRaw = 16'h0000;
    logic [2:0]  cmdType = 3'h0;
    logic [7:0]  cmdId = 8'h00;
    logic [3:0]  cmdLen = 4'h0, measurementSetIndex, rspStatus, rspSetIndex;
    logic [7:0]  cmdData [12];
    logic [7:0]  badIds [3] = '{8'h00, 8'h2A, 8'hFF};
    logic        limitLed, cmdBusy, rspDone;
    logic [31:0] limitViolationStatus, rspWord;
    logic [36:0] expQ [$];
    logic [36:0] expE;
    int          fail_count = 0, n_checks = 0, nSets = 0;
    always #12.5 clk_sys = ~clk_sys;
    pml_link_if link ();
    pml_meter i_pml_meter (.clk_sys(clk_sys), .resetn(resetn), .link(link.meter), .measValid(measValid),
        .measValue(measValue), .currentTransformerFactor(ctFactor), .limitRaw(limitRaw), .limitLed(limitLed),
        .measurementSetIndex(measurementSetIndex), .limitViolationStatus(limitViolationStatus));
    pml_head i_pml_head (.clk_sys(clk_sys), .resetn(resetn), .link(link.head), .cmdValid(cmdValid),
        .cmdType(cmdType), .cmdId(cmdId), .cmdLen(cmdLen), .cmdData(cmdData), .cmdBusy(cmdBusy),
        .rspDone(rspDone), .rspStatus(rspStatus), .rspSetIndex(rspSetIndex), .rspWord(rspWord));
    pml_link_monitor i_pml_link_monitor (.clk_sys(clk_sys), .resetn(resetn), .reqValid(link.reqValid),
        .reqByte(link.reqByte), .rspValid(link.rspValid), .rspByte(link.rspByte));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic req(logic [2:0] t, logic [7:0] id, logic [3:0] n, logic [23:0] d, logic [3:0] s,
                       logic [31:0] w, logic c);
        expQ.push_back({c, s, w});
        @(posedge clk_sys);
        cmdType <= t;
        cmdId <= id;
        cmdLen <= n;
        cmdData[0:2] <= '{d[23:16], d[15:8], d[7:0]};
        cmdValid <= 1'h1;
        @(posedge clk_sys);
        cmdValid <= 1'h0;
        #1 chk("cmdBusy", 32'(cmdBusy), 32'h1);
        repeat (8) begin
            @(posedge clk_sys);
            if (rspDone === 1'h1) break;
        end
    endtask
    task automatic rd(logic [7:0] id, logic [31:0] w);
        req(PML_TT_READ, id, 4'h0, 24'h0, PML_ST_OK, w, 1'h1);
    endtask
    task automatic ack();
        req(PML_TT_CMD, 8'h00, 4'h1, {PML_CMD_ACK, 16'h0}, PML_ST_OK, 32'h0, 1'h0);
        expStat = 32'h0;
    endtask
    task automatic meas(logic [15:0] lim);
        @(posedge clk_sys);
        limitRaw <= lim;
        measValid <= 1'h1;
        @(posedge clk_sys);
        measValid <= 1'h0;
        nSets++;
        expStat |= {16'h0, lim & 16'hFEFF};
    endtask
    // scoreboard: oldest expected note against each completed response
    always @(posedge clk_sys) begin
        if (rspDone === 1'h1) begin
            if (expQ.size() == 0) begin
                chk("unexpected response", 32'h1, 32'h0);
            end else begin
                expE = expQ.pop_front();
                chk("rspStatus", 32'(rspStatus), 32'(expE[35:32]));
                chk("rspSetIndex", 32'(rspSetIndex), 32'(nSets % 15 + 1));
                if (expE[36]) chk("rspWord", rspWord, expE[31:0]);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < 41; i++) measValue[i] = 32'h0;
        for (int i = 0; i < 12; i++) cmdData[i] = 8'h00;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'h1;
        rd(PML_ID_STATUS, PML_STATUS_RESET);
        req(PML_TT_READFR, 8'h00, 4'h0, 24'h0, PML_ST_NOFR, 32'h0, 1'h0);
        for (int t = 5; t < 9; t++) req(3'(t), 8'h01, 4'h0, 24'h0, PML_ST_TYPE, 32'h0, 1'h0);
        foreach (badIds[i]) req(PML_TT_READ, badIds[i], 4'h0, 24'h0, PML_ST_NOID, 32'h0, 1'h0);
        req(PML_TT_CMD, 8'h00, 4'h1, 24'h050000, PML_ST_CMD, 32'h0, 1'h0);
        rd(PML_ID_STATUS, PML_STATUS_RESET);
        ack();
        rd(PML_ID_STATUS, 32'h0);
        repeat (3) begin
            meas(16'(rnd() | 32'h0001));
            rd(PML_ID_STATUS, expStat);
            chk("limitViolationStatus", limitViolationStatus, expStat);
            chk("limitLed", 32'(limitLed), 32'h1);
        end
        @(posedge clk_sys);
        limitRaw <= 16'hFFFF;
        rd(PML_ID_STATUS, expStat);
        meas(16'h0000);
        rd(PML_ID_STATUS, expStat);
        ack();
        rd(PML_ID_STATUS, 32'h0);
        chk("limitLed", 32'(limitLed), 32'h0);
        rv = rnd();
        measValue[0:1] <= '{32'h7F000000, 32'hBF800000};
        measValue[8:11] <= '{32'h7F000000, 32'hFF000000, 32'h4A000000, rv};
        measValue[38:39] <= '{32'h7F000000, 32'h3F800000};
        meas(16'h0000);
        rd(8'h01, PML_F_ENERGY_MAX);
        rd(8'h02, PML_F_ZERO);
        rd(8'h09, PML_F_PTOT_MAX);
        rd(8'h0A, PML_F_PTOT_MIN);
        rd(8'h0B, 32'h4A000000);
        rd(8'h0C, rv);
        rd(PML_ID_OVF_CONS, PML_F_ZERO);
        rd(PML_ID_OVF_PROD, PML_F_ZERO);
        req(PML_TT_SETFR, 8'h00, 4'h4, 24'h0C0927, PML_ST_FRBIG, 32'h0, 1'h0);
        req(PML_TT_SETFR, 8'h00, 4'h3, 24'h0C0927, PML_ST_OK, 32'h0, 1'h0);
        req(PML_TT_READFR, 8'h00, 4'h0, 24'h0, PML_ST_OK, rv, 1'h1);
        repeat (15) meas(16'h0000);
        @(negedge clk_sys);
        chk("measurementSetIndex", 32'(measurementSetIndex), 32'(nSets % 15 + 1));
        chk("pending", 32'(expQ.size()), 32'h0);
        print_verdict();
    end
endmodule
